// >>> bench/dac_chip_model.sv
// Purpose: Behavioural serial four-channel 12-bit converter chip.
// Assumes: Bits shift MSB first on falling sclk while chip select is low.
// Notes:   Levels start at a non-clear pattern so a missed clear shows.
`timescale 1ns/1ps
module dac_chip_model
(
	input  wire logic        sclk_in,
	input  wire logic        sdata_in,
	input  wire logic        cs_n_in,
	input  wire logic        load_n_in,
	output logic      [15:0] frame_out,
	output logic      [4:0]  bits_out,
	output logic      [47:0] levels_out
);
	logic [15:0] shift_reg = 16'h0000;
	logic [4:0]  count_reg = 5'h00;

	initial
	begin
		levels_out = 48'h5A5_5A55_A55A;
		frame_out = 16'h0000;
		bits_out = 5'h00;
	end

	// A new frame restarts the bit count
	always @(negedge cs_n_in)
		count_reg = 5'h00;

	// Shift in on falling sclk, only while selected
	always @(negedge sclk_in)
	begin
		if (!cs_n_in)
		begin
			shift_reg = {shift_reg[14:0], sdata_in};
			count_reg = count_reg + 5'h01;
		end
	end

	// Load strobe moves the held code to the addressed output
	always @(negedge load_n_in)
	begin
		frame_out = shift_reg;
		bits_out = count_reg;
		levels_out[shift_reg[13:12] * 12 +: 12] = shift_reg[11:0];
	end
endmodule

// >>> bench/dac_write_update_control_tb.sv
// Purpose: Self-checking bench for the converter write and update control.
// Assumes: 50 MHz clock; register port with read data one cycle later.
// Notes:   Busy is polled through the status register, never peeked.
`timescale 1ns/1ps
module dac_write_update_control_tb
	import dac_ctrl_pkg::*;
;
	logic        clk_in   = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [3:0]  addr_in  = 4'h0;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in    = 1'b0;
	logic        rd_in    = 1'b0;
	logic        strap_in = 1'b0;
	logic [7:0]  rdata_out;
	logic        irq_out;
	logic        sclk_out;
	logic        sdata_out;
	logic        cs_n_out;
	logic        load_n_out;
	logic [15:0] frame;
	logic [4:0]  nbits;
	logic [47:0] levels;
	logic [7:0]  rd_val;
	int          bad_count   = 0;
	int          checks_done = 0;
	int          cyc         = 0;

	dac_write_update_control dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .clear_mid_strap_in(strap_in),
		.rdata_out(rdata_out), .irq_out(irq_out), .sclk_out(sclk_out), .sdata_out(sdata_out),
		.cs_n_out(cs_n_out), .load_n_out(load_n_out));

	dac_chip_model chip (.sclk_in(sclk_out), .sdata_in(sdata_out), .cs_n_in(cs_n_out),
		.load_n_in(load_n_out), .frame_out(frame), .bits_out(nbits), .levels_out(levels));

	// Clock and a cycle count used to time updates
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
		cyc <= cyc + 1;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 rd_val = rdata_out;
	endtask

	// Bounded poll of the busy bit; reports cycles spent
	task automatic wait_idle(input int limit, output int took);
		int t0;
		t0 = cyc;
		rd_val = 8'h10;
		for (int i = 0; i < limit && rd_val[4] !== 1'b0; i++)
			rd(4'h3);
		took = cyc - t0;
		check("status idle", rd_val, 16'h0000);
	endtask

	task automatic do_reset(input logic strap);
		int took;
		strap_in <= strap;
		rst_n_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		check("reset lines", {rdata_out, cs_n_out, load_n_out, sclk_out}, 16'h0006);
		rst_n_in <= 1'b1;
		rd(4'h3);
		check("busy clearing", rd_val, 16'h0010);
		wait_idle(5000, took);
		for (int c = 0; c < 4; c++)
			check("clear level", levels[c * 12 +: 12], strap ? 12'h800 : 12'h000);
	endtask

	// One full update; low byte write is optional to reuse the stored one
	task automatic update(input logic [1:0] ch, input logic [11:0] code, input bit low);
		int took;
		if (low)
			wr(4'h6, code[7:0]);
		wr(4'h7, {ch, 2'b00, code[11:8]});
		rd(4'h3);
		check("busy after write", rd_val, 16'h0010);
		wait_idle(1000, took);
		check("update time", took >= 1480 && took <= 1530, 16'h0001);
		check("frame", frame, {2'b00, ch, code});
		check("frame bits", nbits, 16'h0010);
		check("level", levels[ch * 12 +: 12], code);
		check("idle lines", {cs_n_out, load_n_out, sclk_out}, 16'h0006);
	endtask

	// Writes during an update are dropped, flagged and interrupt when unmasked
	task automatic overlap();
		int took;
		wr(4'h6, 8'h12);
		wr(4'h7, 8'h44);
		wr(4'h6, 8'hAB);
		wr(4'h7, 8'h8C);
		wait_idle(1000, took);
		check("kept level", levels[12 +: 12], 16'h0412);
		check("untouched level", levels[24 +: 12], 16'h0800);
		rd(4'hC);
		check("irq status", rd_val, 16'h0003);
		check("irq masked", irq_out, 16'h0000);
		wr(4'hD, 8'h02);
		repeat (2) @(posedge clk_in);
		#1 check("irq raised", irq_out, 16'h0001);
		rd(4'hD);
		check("irq mask", rd_val, 16'h0002);
		wr(4'hC, 8'h02);
		repeat (2) @(posedge clk_in);
		#1 check("irq cleared", irq_out, 16'h0000);
		rd(4'hC);
		check("irq status left", rd_val, 16'h0001);
		wr(4'hD, 8'h00);
		wr(4'hC, 8'h01);
	endtask

	// Main sequence
	initial
	begin
		do_reset(1'b0);
		rd(4'hD);
		check("mask reset", rd_val, 16'h0000);
		wr(4'h5, 8'hFF);
		rd(4'h5);
		check("unmapped read", rd_val, 16'h0000);
		wr(4'hC, 8'h03);
		update(2'd0, 12'hFFF, 1'b1);
		update(2'd1, 12'd1776, 1'b1);
		update(2'd2, 12'h800, 1'b1);
		update(2'd3, 12'hB00, 1'b0);
		overlap();
		do_reset(1'b1);
		summarize();
	end

	// Hang guard well beyond the expected span of the run
	initial
	begin
		repeat (60000) @(posedge clk_in);
		bad_count++;
		summarize();
	end
endmodule

// >>> common/dac_ctrl_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the four-channel converter write and update control.
// Assumes: 50 MHz clock; byte-wide register port.
// Notes:   Included by the two design files; the package does not include it.
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH

`define OFS_STATUS        4'h3
`define OFS_CODE_LOW      4'h6
`define OFS_CODE_HIGH     4'h7
`define OFS_IRQ_STATUS    4'hC
`define OFS_IRQ_MASK      4'hD

`define BIT_BUSY          4
`define POS_CHAN_HI       7
`define POS_CHAN_LO       6
`define POS_NIB_HI        3
`define POS_NIB_LO        0

`define RST_BYTE          8'h00
`define RST_MASK          2'h0
`define CODE_MAX          12'hFFF
`define CODE_MID          12'h800

// Irq status bits
`define IRQ_DONE          0
`define IRQ_OVERLAP       1

// Timing: whole update about 30 us; serial clock half period
`define CLK_NS            20
`define UPDATE_NS         30000
`define SCLK_HALF_NS      400
`define SCLK_HALF_CYC     ((`SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define UPDATE_CYC        (`UPDATE_NS / `CLK_NS)
`define LOAD_NS           400
`define LOAD_CYC          ((`LOAD_NS + `CLK_NS - 1) / `CLK_NS)
`define FRAME_BITS        16

`endif

// >>> common/dac_ctrl_pkg.sv
// Purpose: Types shared by the converter control design.
// Assumes: Constants come from dac_ctrl_map.svh.
// Notes:   Holds carriers and state encodings only.
package dac_ctrl_pkg;

	// One update request: channel and 12-bit code
	typedef struct packed {
		logic [1:0]  chan;
		logic [11:0] code;
	} update_req_s;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;

	typedef enum logic [1:0] {
		SH_IDLE  = 2'b00,
		SH_SHIFT = 2'b01,
		SH_LOAD  = 2'b10,
		SH_TAIL  = 2'b11
	} shift_state_e;

endpackage

// >>> rtl/dac_serial_shift.sv
`include "dac_ctrl_map.svh"
// Purpose: Shifts one 16-bit frame to the converter chip, then pulses its load.
// Assumes: Frame is {2'b00, chan, code}, MSB first, data changes on rising sclk, chip samples on falling.
// Notes:   Whole frame plus load and tail fits the documented update time.
`timescale 1ns/1ps
module dac_serial_shift
	import dac_ctrl_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        start_in,
	input  wire update_req_s req_in,
	output logic            busy_out,
	output logic            done_out,
	output logic            sclk_out,
	output logic            sdata_out,
	output logic            cs_n_out,
	output logic            load_n_out
);

	localparam logic [15:0] HALF_CYC = 16'(`SCLK_HALF_CYC);
	localparam logic [15:0] LOAD_CYC = 16'(`LOAD_CYC);
	localparam logic [15:0] UPD_CYC  = 16'(`UPDATE_CYC);

	shift_state_e state_reg;
	logic [15:0]  frame_reg;
	logic [4:0]   bit_reg;
	logic [15:0]  tick_reg;
	logic [15:0]  total_reg;

	// Frame sequencer; tail pads the update to the documented length
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg  <= SH_IDLE;
			frame_reg  <= 16'h0000;
			bit_reg    <= 5'h00;
			tick_reg   <= 16'h0000;
			total_reg  <= 16'h0000;
			sclk_out   <= 1'b0;
			sdata_out  <= 1'b0;
			cs_n_out   <= 1'b1;
			load_n_out <= 1'b1;
			busy_out   <= 1'b0;
			done_out   <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (state_reg != SH_IDLE)
				total_reg <= total_reg + 16'h0001;
			case (state_reg)
				SH_IDLE:
				begin
					if (start_in)
					begin
						frame_reg <= {2'b00, req_in.chan, req_in.code};
						bit_reg   <= 5'h00;
						tick_reg  <= 16'h0000;
						total_reg <= 16'h0000;
						cs_n_out  <= 1'b0;
						sdata_out <= 1'b0;
						busy_out  <= 1'b1;
						state_reg <= SH_SHIFT;
					end
				end
				SH_SHIFT:
				begin
					if (tick_reg == HALF_CYC - 16'h0001)
					begin
						tick_reg <= 16'h0000;
						if (!sclk_out)
						begin
							sdata_out <= frame_reg[15];
							frame_reg <= {frame_reg[14:0], 1'b0};
							sclk_out  <= 1'b1;
						end
						else
						begin
							sclk_out <= 1'b0;
							bit_reg  <= bit_reg + 5'h01;
							// Select stays low past the last falling sclk so the chip
							// never sees select and clock move on the same edge
							if (bit_reg == 5'(`FRAME_BITS - 1))
								state_reg <= SH_LOAD;
						end
					end
					else
						tick_reg <= tick_reg + 16'h0001;
				end
				SH_LOAD:
				begin
					if (load_n_out)
					begin
						cs_n_out   <= 1'b1;
						load_n_out <= 1'b0;
					end
					else if (tick_reg == LOAD_CYC - 16'h0001)
					begin
						tick_reg   <= 16'h0000;
						load_n_out <= 1'b1;
						state_reg  <= SH_TAIL;
					end
					else
						tick_reg <= tick_reg + 16'h0001;
				end
				SH_TAIL:
				begin
					if (total_reg >= UPD_CYC - 16'h0001)
					begin
						busy_out  <= 1'b0;
						done_out  <= 1'b1;
						state_reg <= SH_IDLE;
					end
				end
				default:
					state_reg <= SH_IDLE;
			endcase
		end
	end

	// Load strobe falls only with chip select high, on the same edge that raises it
	load_after_shift_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(load_n_out) |-> cs_n_out && busy_out)
		else $error("load strobe during shift");

	// Busy never drops while load is low
	busy_covers_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!load_n_out |-> busy_out)
		else $error("busy low during load");

endmodule

// >>> rtl/dac_write_update_control.sv
`include "dac_ctrl_map.svh"
// Purpose: Register front end for the four-channel 12-bit converter update path.
// Assumes: One-cycle write and read strobes; read data valid the next cycle.
// Notes:   Overlapping writes during an update are ignored and flagged.
`timescale 1ns/1ps
module dac_write_update_control
	import dac_ctrl_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic       clear_mid_strap_in,
	output logic      [7:0] rdata_out,
	output logic            irq_out,
	output logic            sclk_out,
	output logic            sdata_out,
	output logic            cs_n_out,
	output logic            load_n_out
);

	reg_req_s    req;
	update_req_s upd_req;
	logic [7:0]  low_byte_reg;
	logic        start_reg;
	update_req_s start_req_reg;
	logic        pending_reg;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_mask_reg;
	logic        strap_sync;
	logic        strap_taken_reg;
	logic [1:0]  settle_reg;
	logic        clear_go;
	logic        busy_flag;
	logic [1:0]  clear_chan_reg;
	logic        sh_busy;
	logic        sh_done;
	logic        start_next;
	logic        overlap_ev;
	logic        sh_sclk;
	logic        sh_sdata;
	logic        sh_cs_n;
	logic        sh_load_n;

	// Pack port into carrier
	assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	// Address compare used by several processes
	function automatic logic hit(input reg_req_s r, input logic [3:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	strap_sync u_strap (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.pin_in   (clear_mid_strap_in),
		.sync_out (strap_sync)
	);

	// Joined code: nibble from this write, low byte from the earlier one
	assign upd_req.chan = req.wdata[`POS_CHAN_HI:`POS_CHAN_LO];
	assign upd_req.code = {req.wdata[`POS_NIB_HI:`POS_NIB_LO], low_byte_reg};

	// Writes during an update are dropped, since the chip is mid-frame
	assign start_next = req.wr && hit(req, `OFS_CODE_HIGH) && !pending_reg;
	assign overlap_ev = req.wr && pending_reg
		&& (hit(req, `OFS_CODE_HIGH) || hit(req, `OFS_CODE_LOW));

	// Low byte holding register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			low_byte_reg <= `RST_BYTE;
		else if (req.wr && hit(req, `OFS_CODE_LOW) && !pending_reg)
			low_byte_reg <= req.wdata;
	end

	// Hold off the clear frames until the strap has crossed its synchroniser,
	// otherwise the first frame would carry the synchroniser's reset value
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			settle_reg <= 2'h0;
		else if (settle_reg != 2'h3)
			settle_reg <= settle_reg + 2'h1;
	end

	// Next clear frame may go; busy also covers the wait before the first one
	assign clear_go  = !strap_taken_reg && (settle_reg == 2'h3) && !pending_reg && !start_reg;
	assign busy_flag = pending_reg || !strap_taken_reg;

	// Strap caught after release; a clear frame is sent to every channel
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			strap_taken_reg <= 1'b0;
			clear_chan_reg  <= 2'h0;
		end
		else if (clear_go)
		begin
			if (clear_chan_reg == 2'h3)
				strap_taken_reg <= 1'b1;
			clear_chan_reg <= clear_chan_reg + 2'h1;
		end
	end

	// Start pulse and request to the shifter
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			start_reg     <= 1'b0;
			start_req_reg <= '0;
		end
		else if (!strap_taken_reg)
		begin
			start_reg          <= clear_go;
			start_req_reg.chan <= clear_chan_reg;
			start_req_reg.code <= strap_sync ? `CODE_MID : 12'h000;
		end
		else
		begin
			start_reg <= start_next;
			if (start_next)
				start_req_reg <= upd_req;
		end
	end

	// Busy flag: set on the accepting cycle, cleared when the shifter finishes
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pending_reg <= 1'b0;
		else if (start_next && strap_taken_reg)
			pending_reg <= 1'b1;
		else if (clear_go)
			pending_reg <= 1'b1;
		else if (sh_done)
			pending_reg <= 1'b0;
	end

	dac_serial_shift u_shift (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (start_reg),
		.req_in     (start_req_reg),
		.busy_out   (sh_busy),
		.done_out   (sh_done),
		.sclk_out   (sh_sclk),
		.sdata_out  (sh_sdata),
		.cs_n_out   (sh_cs_n),
		.load_n_out (sh_load_n)
	);

	// Retime the serial pins so every top output is a flop
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sclk_out   <= 1'b0;
			sdata_out  <= 1'b0;
			cs_n_out   <= 1'b1;
			load_n_out <= 1'b1;
		end
		else
		begin
			sclk_out   <= sh_sclk;
			sdata_out  <= sh_sdata;
			cs_n_out   <= sh_cs_n;
			load_n_out <= sh_load_n;
		end
	end

	// Sticky event bits; a new event wins over a write-one clear
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_stat_reg <= 2'h0;
		else
		begin
			logic [1:0] clr;
			logic [1:0] set;
			clr = (req.wr && hit(req, `OFS_IRQ_STATUS)) ? req.wdata[1:0] : 2'h0;
			set = {overlap_ev, sh_done && strap_taken_reg};
			irq_stat_reg <= (irq_stat_reg & ~clr) | set;
		end
	end

	// Interrupt mask
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_mask_reg <= `RST_MASK;
		else if (req.wr && hit(req, `OFS_IRQ_MASK))
			irq_mask_reg <= req.wdata[1:0];
	end

	// Level interrupt, registered
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_stat_reg & irq_mask_reg);
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_out <= 8'h00;
		else if (req.rd)
		begin
			case (req.addr)
				`OFS_STATUS:     rdata_out <= {3'h0, busy_flag, 4'h0};
				`OFS_IRQ_STATUS: rdata_out <= {6'h00, irq_stat_reg};
				`OFS_IRQ_MASK:   rdata_out <= {6'h00, irq_mask_reg};
				default:         rdata_out <= 8'h00;
			endcase
		end
		else
			rdata_out <= 8'h00;
	end

	// Update follows an accepted high-byte write by one cycle
	sequence hi_write_s;
		start_next && strap_taken_reg;
	endsequence

	sequence frame_start_s;
		start_reg ##1 sh_busy;
	endsequence

	hi_write_start_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hi_write_s |=> frame_start_s)
		else $error("high write did not start update");

	busy_same_cycle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hi_write_s |=> pending_reg)
		else $error("busy not set after high write");

	busy_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req.rd && hit(req, `OFS_STATUS) |=> rdata_out[`BIT_BUSY] == $past(busy_flag))
		else $error("busy bit read wrong");

	code_join_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hi_write_s |=> start_req_reg.code == {$past(wdata_in[3:0]), $past(low_byte_reg)})
		else $error("joined code wrong");

	chan_field_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hi_write_s |=> start_req_reg.chan == $past(wdata_in[7:6]))
		else $error("channel field wrong");

	busy_holds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sh_busy |-> pending_reg)
		else $error("busy dropped during shift");

	clear_code_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_reg && !strap_taken_reg |->
			start_req_reg.code == (strap_sync ? `CODE_MID : 12'h000))
		else $error("clear code wrong");

	idle_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!busy_flag && !sh_busy ##1 req.rd && hit(req, `OFS_STATUS) && !busy_flag
			|=> !rdata_out[`BIT_BUSY])
		else $error("busy bit set while idle");

endmodule

// >>> rtl/strap_sync.sv
// Purpose: Two-flop synchroniser for the clear-code strap pin.
// Assumes: Pin is asynchronous to clk_in.
// Notes:   First flop is read by the second only.
`timescale 1ns/1ps
module strap_sync
	import dac_ctrl_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic pin_in,
	output logic      sync_out
);

	logic meta_reg;

	// Metastability guard on the pin
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end

endmodule
